// ### tb/sac_host_model.sv
// host model: conversion strobe, serial clock and frames
`timescale 1ns/1ns
module sac_host_model (
  input  wire logic clk,
  input  wire logic sdo_out,
  input  wire logic sdo_oe,
  output logic      sck,
  output logic      strobe,
  output logic      sdi
);
  logic sdo_last;
  logic sdo_w;
  // released line shows the inverse of its last driven level
  assign sdo_w = sdo_oe ? sdo_out : ~sdo_last;
  always @(posedge clk) if (sdo_oe) sdo_last <= sdo_out;
  initial begin
    sck = 1'b0;
    strobe = 1'b1;
    sdi = 1'b1;
    sdo_last = 1'b0;
  end
  task automatic start_conv(input logic mode, input logic tie,
                            input logic hold);
    @(negedge clk);
    sdi = tie ? 1'b0 : mode;
    strobe = 1'b0;
    repeat (2) @(negedge clk);
    strobe = 1'b1;
    if (tie) sdi = 1'b1;
    repeat (5) @(negedge clk);
    sdi = 1'b1;
    if (hold) strobe = 1'b0;
  endtask
  // sck stands still outside frames; odd offset keeps phase unrelated
  task automatic xfer(input logic [23:0] tx, input int n, input logic last,
                      output logic [23:0] rx);
    rx = '0;
    @(negedge clk);
    strobe = 1'b0;
    #103;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #40 sck = 1'b1;
      #35 rx[i] = sdo_w;
      #5 sck = 1'b0;
    end
    sdi = last;
    #40;
    @(negedge clk);
    strobe = 1'b1;
    repeat (40) @(negedge clk);
  endtask
endmodule

// ### tb/sar_adc_serial_config_port_bench.sv
// self-checking bench for the converter serial configuration port
`timescale 1ns/1ns
module sar_adc_serial_config_port_bench;
  import sac_pkg::*;
  logic        clk_sys;
  logic        rst_n;
  logic        sck;
  logic        strobe;
  logic        sdi;
  sac_result_t conv_result;
  logic        overvoltage;
  logic        sdo_out;
  logic        sdo_oe;
  logic        acquire;
  logic        power_down;
  logic        daisy_mode;
  logic        turbo_en;
  logic        span_compress;
  logic        highz_en;
  logic        status_en;
  logic [7:0]  v;
  logic [23:0] rx;
  int          n;
  int          n_mismatch;
  int          checked;

  sac_serial_port uut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .SCK(sck),
    .CONVERSION_STROBE(strobe), .SDI(sdi), .CONV_RESULT(conv_result),
    .OVERVOLTAGE(overvoltage), .SDO_OUT(sdo_out), .SDO_OE(sdo_oe),
    .ACQUIRE(acquire), .POWER_DOWN(power_down), .DAISY_MODE(daisy_mode),
    .TURBO_EN(turbo_en), .SPAN_COMPRESS(span_compress),
    .HIGHZ_EN(highz_en), .STATUS_EN(status_en)
  );
  sac_host_model host (
    .clk(clk_sys), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .sck(sck), .strobe(strobe), .sdi(sdi)
  );

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // sel 0 watches power_down, 1 watches acquire; counts cycles waited
  task automatic wait_out(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    while ((sel == 0 ? power_down : acquire) !== lvl) begin
      @(negedge clk_sys);
      cnt++;
      if (cnt > 300) begin
        n_mismatch++;
        finish_test();
      end
    end
  endtask

  task automatic read_cfg(output logic [7:0] val);
    logic [23:0] r;
    host.xfer(24'h0054ff, 16, 1'b1, r);
    val = r[7:0];
  endtask

  task automatic write_cfg(input logic [7:0] d, input logic last);
    logic [23:0] r;
    host.xfer({8'h00, 8'h14, d}, 16, last, r);
  endtask

  task automatic do_conv();
    host.start_conv(1'b1, 1'b0, 1'b0);
    wait_out(0, 1'b0, n);
    wait_out(0, 1'b1, n);
  endtask

  task automatic t_power_up();
    chk({status_en, span_compress, highz_en, turbo_en}, 24'h0);
    @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(sdo_oe, 24'h0);
    host.sdi = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk({sdo_oe, sdo_out}, 24'h2);
    host.sdi = 1'b1;
    // first strobe rise ends the power-up output state
    do_conv();
    read_cfg(v);
    chk(v, 24'he1);
  endtask

  task automatic t_config();
    host.xfer({8'hff, 8'h14, 8'h1e}, 24, 1'b1, rx);
    chk({status_en, span_compress, highz_en, turbo_en}, 24'hf);
    host.xfer(24'h009400, 16, 1'b1, rx);
    host.xfer(24'h001600, 16, 1'b1, rx);
    chk({status_en, span_compress, highz_en, turbo_en}, 24'hf);
    read_cfg(v);
    chk(v, 24'hff);
  endtask

  task automatic t_conv_status();
    conv_result = 16'ha5c3;
    host.start_conv(1'b1, 1'b0, 1'b0);
    wait_out(0, 1'b0, n);
    chk(daisy_mode, 24'h0);
    wait_out(1, 1'b1, n);
    // start_conv returns two cycles after acquire falls
    chk(24'(n + 2), 24'(ACQ_AT_CYCLE));
    wait_out(0, 1'b1, n);
    chk(n, ACQ_EARLY_CYC);
    host.xfer(24'hffffff, 23, 1'b1, rx);
    chk(rx[22:0], {16'ha5c3, 6'b111100, 1'b1});
    chk(sdo_oe, 24'h0);
  endtask

  task automatic t_busy();
    write_cfg(8'h10, 1'b1);
    conv_result = 16'h3c5a;
    host.start_conv(1'b1, 1'b0, 1'b1);
    wait_out(0, 1'b0, n);
    wait_out(0, 1'b1, n);
    repeat (2) @(negedge clk_sys);
    chk({sdo_oe, sdo_out}, 24'h2);
    host.xfer(24'hffffff, 23, 1'b1, rx);
    chk(rx[22:0], {1'b0, 16'h3c5a, 6'b100000});
  endtask

  task automatic t_daisy();
    host.start_conv(1'b0, 1'b1, 1'b0);
    wait_out(0, 1'b0, n);
    chk(daisy_mode, 24'h1);
    write_cfg(8'h12, 1'b0);
    chk({status_en, turbo_en}, 24'h3);
    chk({daisy_mode, sdo_oe, sdo_out}, 24'h6);
  endtask

  task automatic t_ovflag();
    overvoltage = 1'b1;
    do_conv();
    overvoltage = 1'b0;
    do_conv();
    read_cfg(v);
    chk(v, 24'hf2);
    read_cfg(v);
    read_cfg(v);
    chk(v, 24'hf3);
  endtask

  initial begin
    n_mismatch = 0;
    checked = 0;
    rst_n = 1'b0;
    conv_result = '0;
    overvoltage = 1'b0;
    repeat (20) @(negedge clk_sys);
    t_power_up();
    t_config();
    t_conv_status();
    t_busy();
    t_daisy();
    t_ovflag();
    finish_test();
  end
endmodule

// ### verilog/sac_link_if.sv
// interface: serial clock domain to system clock domain crossing signals
`timescale 1ns/1ns
interface sac_link_if;
  logic       wr_tgl;
  logic [7:0] wr_data;
  logic       rd_tgl;
  logic [4:0] out_gray;

  modport engine (output wr_tgl, output wr_data, output rd_tgl,
                  output out_gray);
  modport core   (input wr_tgl, input wr_data, input rd_tgl,
                  input out_gray);
endinterface

// ### verilog/sac_pkg.sv
// package: constants and types for the converter serial configuration port
// Contract
// - conversion ends within 290 ns; acquisition resumes about 100 ns earlier.
// - converter powers down automatically after every conversion.
// - strobe rise samples serial input: high chip-select mode, low daisy-chain.
// - serial input tied to strobe always gives daisy-chain mode.
// - chip-select mode, turbo off: start bit if strobe or input low at end.
// - at power-up output floats only when strobe and input both high.
// - turbo set by configuration register and suppresses the busy start bit.
// - status enabled appends six status bits after the result.
// - configuration frame is 16 bits, strobe low: command then data.
// - overvoltage flag active low, sticky, restored only by read once clear.
// - after reset all enable bits are 0 and overvoltage flag is 1.
// - command receiver skips ones until first zero, then takes eight bits.
// - command bit 7 write enable, bit 6 read/write, bits 5..0 010100.
// - strobe low for access; input sampled on rise, output on fall.
// - strobe rise floats output, or drives it low in daisy-chain mode.
// - writes apply always; host lowers strobe after conversion for valid data.
// - register 0x0 holds status, span, high-z, turbo, flag; reset 0xe1.
// - strobe rise with input high starts a chip-select mode conversion.
// - status order: flag, span, high-z, turbo, two reserved; then float.
package sac_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS  = 290;
  localparam int ACQ_EARLY_NS  = 100;
  localparam int CONV_CYCLES   = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int ACQ_EARLY_CYC = ACQ_EARLY_NS / CLK_PERIOD_NS;
  localparam int ACQ_AT_CYCLE  = CONV_CYCLES - ACQ_EARLY_CYC;

  localparam logic [4:0] CONV_LAST = 5'(CONV_CYCLES - 1);
  localparam logic [4:0] ACQ_LAST  = 5'(ACQ_AT_CYCLE - 1);

  localparam int RESULT_BITS = 16;
  localparam int STATUS_BITS = 6;
  localparam int SEQ_BITS    = RESULT_BITS + STATUS_BITS;

  localparam logic [4:0] CMD_LAST    = 5'h07;
  localparam logic [4:0] FRAME_LAST  = 5'h0f;
  localparam logic [4:0] FRAME_END   = 5'h10;
  localparam logic [4:0] CNT_MAX     = 5'h1f;
  localparam logic [4:0] REG_OUT_LEN = 5'h08;
  localparam logic [4:0] RESULT_LEN  = 5'h10;
  localparam logic [4:0] STATUS_LEN  = 5'h06;
  localparam logic [4:0] SEQ_TOP     = 5'h15;

  localparam logic [1:0] CFG_ADDR      = 2'h0;
  localparam logic [7:0] CFG_RESET     = 8'he1;
  localparam int         CFG_STAT_BIT  = 4;
  localparam int         CFG_SPAN_BIT  = 3;
  localparam int         CFG_HIZ_BIT   = 2;
  localparam int         CFG_TURBO_BIT = 1;
  localparam int         CFG_OV_BIT    = 0;

  localparam int         CMD_WEN_BIT = 7;
  localparam int         CMD_RW_BIT  = 6;
  localparam logic [5:0] CMD_PATTERN = 6'h14;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b01,
    SAC_CONV = 2'b10
  } sac_conv_e;

  typedef logic [RESULT_BITS-1:0] sac_result_t;

endpackage

// ### verilog/sac_sck_engine.sv
// module: serial clock domain command receiver and output bit counter
`timescale 1ns/1ns
module sac_sck_engine (
  input  wire logic  sck,
  input  wire logic  rst_n,
  input  wire logic  conversion_strobe,
  input  wire logic  sdi,
  sac_link_if.engine lnk
);
  import sac_pkg::*;

  logic       frame_rst_n;
  logic       started_ff;
  logic [4:0] in_cnt_ff;
  logic [6:0] in_sh_ff;
  logic [7:0] cmd_ff;
  logic [7:0] wr_data_ff;
  logic       wr_tgl_ff;
  logic       rd_tgl_ff;
  logic [4:0] out_cnt_ff;
  logic [4:0] gray_ff;
  logic [7:0] nxt_byte;
  logic [4:0] nxt_out_cnt;
  logic       byte_ok;
  logic       cmd_wr_ok;

  // frame logic held clear while the strobe is high
  assign frame_rst_n = rst_n & ~conversion_strobe;
  assign nxt_byte    = {in_sh_ff, sdi};
  assign byte_ok     = ~nxt_byte[CMD_WEN_BIT] &
                       (nxt_byte[5:0] == CMD_PATTERN);
  assign cmd_wr_ok   = ~cmd_ff[CMD_WEN_BIT] & ~cmd_ff[CMD_RW_BIT] &
                       (cmd_ff[5:0] == CMD_PATTERN);
  assign nxt_out_cnt = (out_cnt_ff == CNT_MAX) ? CNT_MAX :
                       out_cnt_ff + 5'h01;

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      started_ff <= 1'b0;
      in_cnt_ff  <= 5'h00;
      in_sh_ff   <= 7'h00;
      cmd_ff     <= 8'h00;
    end else if (!started_ff) begin
      if (!sdi) begin
        started_ff <= 1'b1;
        in_cnt_ff  <= 5'h01;
      end
    end else if (in_cnt_ff != FRAME_END) begin
      in_sh_ff  <= nxt_byte[6:0];
      in_cnt_ff <= in_cnt_ff + 5'h01;
      if (in_cnt_ff == CMD_LAST) begin
        cmd_ff <= nxt_byte;
      end
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rd_tgl_ff  <= 1'b0;
      wr_tgl_ff  <= 1'b0;
      wr_data_ff <= 8'h00;
    end else if (started_ff) begin
      if (in_cnt_ff == CMD_LAST && byte_ok && nxt_byte[CMD_RW_BIT]) begin
        rd_tgl_ff <= ~rd_tgl_ff;
      end
      if (in_cnt_ff == FRAME_LAST && cmd_wr_ok) begin
        wr_data_ff <= nxt_byte;
        wr_tgl_ff  <= ~wr_tgl_ff;
      end
    end
  end

  // falling edges advance the output bit; gray code for the crossing
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_cnt_ff <= 5'h00;
      gray_ff    <= 5'h00;
    end else begin
      out_cnt_ff <= nxt_out_cnt;
      gray_ff    <= nxt_out_cnt ^ (nxt_out_cnt >> 1);
    end
  end

  assign lnk.wr_tgl   = wr_tgl_ff;
  assign lnk.wr_data  = wr_data_ff;
  assign lnk.rd_tgl   = rd_tgl_ff;
  assign lnk.out_gray = gray_ff;

endmodule

// ### verilog/sac_serial_port.sv
// module: converter serial port top with conversion control and config
`timescale 1ns/1ns
module sac_serial_port (
  input  wire logic          CLK_SYS,
  input  wire logic          RST_N,
  input  wire logic          SCK,
  input  wire logic          CONVERSION_STROBE,
  input  wire logic          SDI,
  input  sac_pkg::sac_result_t CONV_RESULT,
  input  wire logic          OVERVOLTAGE,
  output logic               SDO_OUT,
  output logic               SDO_OE,
  output logic               ACQUIRE,
  output logic               POWER_DOWN,
  output logic               DAISY_MODE,
  output logic               TURBO_EN,
  output logic               SPAN_COMPRESS,
  output logic               HIGHZ_EN,
  output logic               STATUS_EN
);
  import sac_pkg::*;

  sac_link_if lnk ();

  sac_sck_engine u_engine (
    .sck (SCK),
    .rst_n (RST_N),
    .conversion_strobe (CONVERSION_STROBE),
    .sdi (SDI),
    .lnk (lnk)
  );

  function automatic logic [4:0] gray2bin(input logic [4:0] g);
    logic [4:0] b;
    b[4] = g[4];
    for (int i = 3; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  logic        cnv_s1_ff;
  logic        cnv_s2_ff;
  logic        cnv_d_ff;
  logic        sdi_s1_ff;
  logic        sdi_s2_ff;
  logic        sdi_d_ff;
  logic        wr_s1_ff;
  logic        wr_s2_ff;
  logic        wr_d_ff;
  logic        rd_s1_ff;
  logic        rd_s2_ff;
  logic        rd_d_ff;
  logic [4:0]  gray_s1_ff;
  logic [4:0]  gray_s2_ff;

  sac_conv_e   state_ff;
  logic [4:0]  conv_cnt_ff;
  sac_result_t result_ff;
  logic        busy_ind_ff;
  logic        ov_flag_n_ff;
  logic        pwrup_ff;
  logic        rd_act_ff;
  logic [4:0]  rd_base_ff;
  logic        nxt_sdo;
  logic        nxt_oe;

  logic        cnv_rise;
  logic        wr_evt;
  logic        rd_evt;
  logic        conv_end;
  logic [4:0]  cnt_bin;
  logic [4:0]  rd_idx;
  logic [4:0]  seq_idx;
  logic [4:0]  seq_pos;
  logic [4:0]  frame_len;
  logic        frame_on;
  logic [7:0]  cfg_rd;
  logic [5:0]  status;
  logic [SEQ_BITS-1:0] seq;

  // synchronisers; strobe and input reset to idle high, no false edge
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cnv_s1_ff  <= 1'b1;
      cnv_s2_ff  <= 1'b1;
      cnv_d_ff   <= 1'b1;
      sdi_s1_ff  <= 1'b1;
      sdi_s2_ff  <= 1'b1;
      sdi_d_ff   <= 1'b1;
      wr_s1_ff   <= 1'b0;
      wr_s2_ff   <= 1'b0;
      wr_d_ff    <= 1'b0;
      rd_s1_ff   <= 1'b0;
      rd_s2_ff   <= 1'b0;
      rd_d_ff    <= 1'b0;
      gray_s1_ff <= 5'h00;
      gray_s2_ff <= 5'h00;
    end else begin
      cnv_s1_ff  <= CONVERSION_STROBE;
      cnv_s2_ff  <= cnv_s1_ff;
      cnv_d_ff   <= cnv_s2_ff;
      sdi_s1_ff  <= SDI;
      sdi_s2_ff  <= sdi_s1_ff;
      sdi_d_ff   <= sdi_s2_ff;
      wr_s1_ff   <= lnk.wr_tgl;
      wr_s2_ff   <= wr_s1_ff;
      wr_d_ff    <= wr_s2_ff;
      rd_s1_ff   <= lnk.rd_tgl;
      rd_s2_ff   <= rd_s1_ff;
      rd_d_ff    <= rd_s2_ff;
      gray_s1_ff <= lnk.out_gray;
      gray_s2_ff <= gray_s1_ff;
    end
  end

  assign cnv_rise = cnv_s2_ff & ~cnv_d_ff;
  assign wr_evt   = wr_s2_ff ^ wr_d_ff;
  assign rd_evt   = rd_s2_ff ^ rd_d_ff;
  assign cnt_bin  = gray2bin(gray_s2_ff);
  assign conv_end = (state_ff == SAC_CONV) && (conv_cnt_ff == CONV_LAST);

  // mode chosen from the input level one cycle before the strobe edge
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      DAISY_MODE <= 1'b0;
      pwrup_ff   <= 1'b1;
    end else if (cnv_rise) begin
      DAISY_MODE <= ~sdi_d_ff;
      pwrup_ff   <= 1'b0;
    end
  end

  // conversion timing, acquisition and power-down
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_ff    <= SAC_IDLE;
      conv_cnt_ff <= 5'h00;
      ACQUIRE     <= 1'b1;
      POWER_DOWN  <= 1'b1;
    end else begin
      case (state_ff)
        SAC_IDLE: begin
          if (cnv_rise) begin
            state_ff    <= SAC_CONV;
            conv_cnt_ff <= 5'h00;
            ACQUIRE     <= 1'b0;
            POWER_DOWN  <= 1'b0;
          end
        end
        SAC_CONV: begin
          conv_cnt_ff <= conv_cnt_ff + 5'h01;
          if (conv_cnt_ff == ACQ_LAST) begin
            ACQUIRE <= 1'b1;
          end
          if (conv_end) begin
            state_ff   <= SAC_IDLE;
            POWER_DOWN <= 1'b1;
          end
        end
        default: begin
          state_ff <= SAC_IDLE;
        end
      endcase
    end
  end

  // result capture and busy indicator
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      result_ff   <= '0;
      busy_ind_ff <= 1'b0;
    end else if (conv_end) begin
      result_ff   <= CONV_RESULT;
      busy_ind_ff <= ~DAISY_MODE & ~TURBO_EN &
                     (~cnv_s2_ff | ~sdi_s2_ff);
    end else if (cnv_rise) begin
      busy_ind_ff <= 1'b0;
    end
  end

  // configuration register, writes accepted in any conversion state
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      STATUS_EN     <= CFG_RESET[CFG_STAT_BIT];
      SPAN_COMPRESS <= CFG_RESET[CFG_SPAN_BIT];
      HIGHZ_EN      <= CFG_RESET[CFG_HIZ_BIT];
      TURBO_EN      <= CFG_RESET[CFG_TURBO_BIT];
    end else if (wr_evt) begin
      STATUS_EN     <= lnk.wr_data[CFG_STAT_BIT];
      SPAN_COMPRESS <= lnk.wr_data[CFG_SPAN_BIT];
      HIGHZ_EN      <= lnk.wr_data[CFG_HIZ_BIT];
      TURBO_EN      <= lnk.wr_data[CFG_TURBO_BIT];
    end
  end

  // sticky flag: cleared as a read frame ends; new overvoltage wins
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ov_flag_n_ff <= CFG_RESET[CFG_OV_BIT];
    end else if (conv_end && OVERVOLTAGE) begin
      ov_flag_n_ff <= 1'b0;
    end else if (cnv_rise && rd_act_ff && !OVERVOLTAGE) begin
      ov_flag_n_ff <= 1'b1;
    end
  end

  // register read window; reads refused in daisy-chain mode
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rd_act_ff  <= 1'b0;
      rd_base_ff <= 5'h00;
    end else if (cnv_rise) begin
      rd_act_ff  <= 1'b0;
    end else if (rd_evt && !DAISY_MODE) begin
      rd_act_ff  <= 1'b1;
      rd_base_ff <= cnt_bin + 5'h01;
    end
  end

  assign cfg_rd = {CFG_RESET[7:5], STATUS_EN, SPAN_COMPRESS, HIGHZ_EN,
                   TURBO_EN, ov_flag_n_ff};
  assign status = {ov_flag_n_ff, SPAN_COMPRESS, HIGHZ_EN, TURBO_EN,
                   2'b00};
  assign seq    = {result_ff, status};
  assign frame_len = RESULT_LEN + (STATUS_EN ? STATUS_LEN : 5'h00) +
                     {4'h0, busy_ind_ff};
  assign frame_on  = ((state_ff == SAC_IDLE) | TURBO_EN) &
                     (~cnv_s2_ff | busy_ind_ff);
  assign rd_idx  = cnt_bin - rd_base_ff;
  assign seq_idx = busy_ind_ff ? cnt_bin - 5'h01 : cnt_bin;
  assign seq_pos = SEQ_TOP - seq_idx;

  always_comb begin
    nxt_oe  = 1'b0;
    nxt_sdo = 1'b0;
    if (pwrup_ff) begin
      nxt_oe = ~(cnv_s2_ff & sdi_s2_ff);
    end else if (DAISY_MODE) begin
      nxt_oe = 1'b1;
    end else if (rd_act_ff) begin
      if (rd_idx < REG_OUT_LEN) begin
        nxt_oe  = 1'b1;
        nxt_sdo = cfg_rd[3'h7 - rd_idx[2:0]];
      end
    end else if (frame_on && cnt_bin < frame_len) begin
      nxt_oe = 1'b1;
      if (busy_ind_ff && cnt_bin == 5'h00) begin
        nxt_sdo = 1'b0;
      end else begin
        nxt_sdo = seq[seq_pos];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SDO_OE  <= 1'b1;
      SDO_OUT <= 1'b0;
    end else begin
      SDO_OE  <= nxt_oe;
      SDO_OUT <= nxt_sdo;
    end
  end

  localparam int A_CONV_CYC = CONV_CYCLES;
  localparam int A_ACQ_AT   = ACQ_AT_CYCLE;

  default clocking a_clk @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  a_conv_time: assert property (
    $rose(state_ff == SAC_CONV) |-> ##A_CONV_CYC (state_ff == SAC_IDLE))
    else $error("conversion length wrong");

  a_acq_early: assert property (
    $rose(state_ff == SAC_CONV) |->
      !ACQUIRE ##A_ACQ_AT (ACQUIRE && state_ff == SAC_CONV))
    else $error("acquisition not resumed early");

  a_power_down: assert property (
    POWER_DOWN == (state_ff == SAC_IDLE))
    else $error("power-down out of step with conversion");

  a_mode_select: assert property (
    cnv_rise |=> (DAISY_MODE == !$past(sdi_d_ff)))
    else $error("mode not taken from input level");

  a_tied_daisy: assert property (
    (cnv_rise && sdi_s2_ff && !sdi_d_ff) |=> DAISY_MODE)
    else $error("tied input did not give daisy-chain");

  a_busy_start: assert property (
    (busy_ind_ff && !DAISY_MODE && !rd_act_ff && !pwrup_ff &&
     cnt_bin == 5'h00 && frame_on) |=> (SDO_OE && !SDO_OUT))
    else $error("busy start bit missing");

  a_pwrup_out: assert property (
    (pwrup_ff && cnv_s2_ff && sdi_s2_ff) |=> !SDO_OE)
    else $error("power-up output not floating");

  a_turbo_nobusy: assert property (
    (conv_end && TURBO_EN) |=> !busy_ind_ff)
    else $error("busy bit set in turbo");

  a_ov_sticky: assert property (
    (!ov_flag_n_ff && !(cnv_rise && rd_act_ff)) |=> !ov_flag_n_ff)
    else $error("overvoltage flag cleared without read");

  a_daisy_low: assert property (
    (DAISY_MODE && !pwrup_ff) |=> (SDO_OE && !SDO_OUT))
    else $error("daisy-chain output not low");

  a_cs_float: assert property (
    (cnv_rise && sdi_d_ff && !pwrup_ff) |=> ##1 !SDO_OE)
    else $error("output not floated on strobe rise");

  a_write_cfg: assert property (
    wr_evt |=> (TURBO_EN == $past(lnk.wr_data[CFG_TURBO_BIT])))
    else $error("register write not applied");

endmodule
